/* File: rtl/mdsl_pkg.sv */
// shared constants, types and frame helpers for the serial channel loader
package mdsl_pkg;

  localparam int NUM_CH     = 32;
  localparam int ADDR_W     = 5;
  localparam int CODE_W     = 14;
  localparam int FRAME_BITS = ADDR_W + CODE_W;
  localparam int ADDR_LSB   = CODE_W;
  localparam int CODE_LSB   = 0;

  localparam logic [CODE_W-1:0] CODE_RESET = 14'h0000;
  localparam logic [CODE_W-1:0] CODE_MAX   = 14'h3fff;

  // link clock: device bit counter counts the edges of one frame
  localparam int          CNT_W        = 5;
  localparam logic [CNT_W-1:0] LAST_BIT_IDX = CNT_W'(FRAME_BITS - 1);
  localparam logic [CNT_W-1:0] FRAME_CNT    = CNT_W'(FRAME_BITS);

  // timing of the host side, all derived from the system clock
  localparam int CLOCK_PERIOD_PS  = 4000;
  localparam int SCLK_MAX_KHZ     = 30000;
  localparam int SCLK_MIN_PER_PS  = (1000000000 + SCLK_MAX_KHZ - 1) / SCLK_MAX_KHZ;
  localparam int SCLK_HALF_CYCLES = (SCLK_MIN_PER_PS + 2 * CLOCK_PERIOD_PS - 1)
                                    / (2 * CLOCK_PERIOD_PS);
  localparam int GAP_NS           = 200;
  localparam int GAP_CYCLES       = (GAP_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;

  localparam int DIV_W = 3;
  localparam int GAP_W = 6;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF_CYCLES - 1);
  localparam logic [GAP_W-1:0] GAP_LAST = GAP_W'(GAP_CYCLES - 1);

  typedef logic [FRAME_BITS-1:0]           mdsl_frame_type;
  typedef logic [NUM_CH-1:0][CODE_W-1:0]   mdsl_code_array_type;

  function automatic logic [ADDR_W-1:0] frame_addr(input mdsl_frame_type w);
    frame_addr = w[ADDR_LSB +: ADDR_W];
  endfunction

  function automatic logic [CODE_W-1:0] frame_code(input mdsl_frame_type w);
    frame_code = w[CODE_LSB +: CODE_W];
  endfunction

  function automatic mdsl_frame_type frame_pack(input logic [ADDR_W-1:0] a,
                                                input logic [CODE_W-1:0] c);
    frame_pack = {a, c};
  endfunction

endpackage

/* File: rtl/mdsl_link_if.sv */
// three-wire link plus broadcast-load and reset pins between host and device
`timescale 1ns/100ps
interface mdsl_link_if;
  logic sync_n;
  logic sclk;
  logic din;
  logic broadcast;
  logic reset_n;

  modport host (
    output sync_n,
    output sclk,
    output din,
    output broadcast,
    output reset_n
  );

  modport device (
    input sync_n,
    input sclk,
    input din,
    input broadcast,
    input reset_n
  );
endinterface

/* File: rtl/mdsl_device.sv */
// device end: frame receiver on the link clock, channel code store, system-side mirror
`timescale 1ns/100ps
module mdsl_device
  import mdsl_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        reset,
  mdsl_link_if.device                      link,
  output      mdsl_pkg::mdsl_code_array_type channel_code,
  output      logic                        update_pulse,
  output      logic [mdsl_pkg::ADDR_W-1:0] update_channel,
  output      logic                        update_broadcast
);
  import mdsl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // link-clock domain state

  typedef enum logic [0:0] {
    RX_IDLE,
    RX_SHIFT
  } mdsl_rx_state_type;

  typedef struct packed {
    mdsl_rx_state_type   st;
    logic [CNT_W-1:0]    cnt;
    logic [FRAME_BITS-2:0] sh;
    logic                seen_tog;
    logic                load_tog;
    logic [ADDR_W-1:0]   last_addr;
    logic [CODE_W-1:0]   last_code;
    logic                last_bcast;
    mdsl_code_array_type chan;
  } mdsl_rx_regs_type;

  mdsl_rx_regs_type rx_r;
  mdsl_rx_regs_type rx_nxt;

  // flips on every frame sync fall; with a gated clock the fall may come
  // while the serial clock stands still, so it is caught on its own edge
  logic             frame_tog_r;

  mdsl_frame_type   rx_word;

  always_ff @(negedge link.sync_n or negedge link.reset_n) begin
    if (!link.reset_n) begin
      frame_tog_r <= 1'b0;
    end else begin
      frame_tog_r <= ~frame_tog_r;
    end
  end

  always_comb begin
    rx_nxt  = rx_r;
    rx_word = {rx_r.sh, link.din};
    case (rx_r.st)
      RX_IDLE: begin
        // a start needs an unconsumed sync fall with sync still low
        if ((frame_tog_r != rx_r.seen_tog) && !link.sync_n) begin
          rx_nxt.seen_tog = frame_tog_r;
          rx_nxt.sh       = {{(FRAME_BITS-2){1'b0}}, link.din};
          rx_nxt.cnt      = CNT_W'(1);
          rx_nxt.st       = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        rx_nxt.sh = {rx_r.sh[FRAME_BITS-3:0], link.din};
        if (rx_r.cnt == LAST_BIT_IDX) begin
          rx_nxt.last_addr  = frame_addr(rx_word);
          rx_nxt.last_code  = frame_code(rx_word);
          rx_nxt.last_bcast = link.broadcast;
          for (int i = 0; i < NUM_CH; i++) begin
            if (link.broadcast || (frame_addr(rx_word) == ADDR_W'(i))) begin
              rx_nxt.chan[i] = frame_code(rx_word);
            end
          end
          rx_nxt.load_tog = ~rx_r.load_tog;
          // sync falls seen during the frame are absorbed here
          rx_nxt.seen_tog = frame_tog_r;
          rx_nxt.cnt      = FRAME_CNT;
          rx_nxt.st       = RX_IDLE;
        end else begin
          rx_nxt.cnt = rx_r.cnt + CNT_W'(1);
        end
      end
      default: begin
        rx_nxt.st = RX_IDLE;
      end
    endcase
  end

  // the serial clock is the only clock this logic sees, gated or not
  always_ff @(negedge link.sclk or negedge link.reset_n) begin
    if (!link.reset_n) begin
      rx_r <= '0;
    end else begin
      rx_r <= rx_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // system-clock domain: mirror of the channel store

  typedef struct packed {
    logic                tog_s1;
    logic                tog_s2;
    logic                tog_s3;
    logic                rst_s1;
    logic                rst_s2;
    mdsl_code_array_type chan;
    logic                upd;
    logic [ADDR_W-1:0]   upd_ch;
    logic                upd_bc;
  } mdsl_sys_regs_type;

  mdsl_sys_regs_type sys_r;
  mdsl_sys_regs_type sys_nxt;

  always_comb begin
    sys_nxt        = sys_r;
    sys_nxt.tog_s1 = rx_r.load_tog;
    sys_nxt.tog_s2 = sys_r.tog_s1;
    sys_nxt.tog_s3 = sys_r.tog_s2;
    sys_nxt.rst_s1 = link.reset_n;
    sys_nxt.rst_s2 = sys_r.rst_s1;
    sys_nxt.upd    = 1'b0;
    // last_* stand still for a whole frame after the toggle, far longer
    // than the two-stage delay, so they are read here without a second stage
    if (sys_r.tog_s2 != sys_r.tog_s3) begin
      sys_nxt.upd    = 1'b1;
      sys_nxt.upd_ch = rx_r.last_addr;
      sys_nxt.upd_bc = rx_r.last_bcast;
      for (int i = 0; i < NUM_CH; i++) begin
        if (rx_r.last_bcast || (rx_r.last_addr == ADDR_W'(i))) begin
          sys_nxt.chan[i] = rx_r.last_code;
        end
      end
    end
    if (!sys_r.rst_s2) begin
      sys_nxt.chan   = '0;
      sys_nxt.upd    = 1'b0;
      sys_nxt.upd_ch = '0;
      sys_nxt.upd_bc = 1'b0;
      sys_nxt.tog_s3 = sys_r.tog_s2;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      sys_r <= '0;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  assign channel_code     = sys_r.chan;
  assign update_pulse     = sys_r.upd;
  assign update_channel   = sys_r.upd_ch;
  assign update_broadcast = sys_r.upd_bc;

endmodule // mdsl_device

/* File: rtl/mdsl_host.sv */
// host end: frames channel writes onto the link from a divided system clock
`timescale 1ns/100ps
module mdsl_host
  import mdsl_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        reset,
  input  wire logic                        start,
  input  wire logic [mdsl_pkg::ADDR_W-1:0] channel,
  input  wire logic [mdsl_pkg::CODE_W-1:0] code,
  input  wire logic                        broadcast_req,
  input  wire logic                        dev_reset_req,
  output      logic                        ready,
  mdsl_link_if.host                        link
);
  import mdsl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef enum logic [1:0] {
    HS_IDLE,
    HS_HIGH,
    HS_LOW,
    HS_GAP
  } mdsl_host_state_type;

  typedef struct packed {
    mdsl_host_state_type st;
    logic [DIV_W-1:0]    div;
    logic [CNT_W-1:0]    idx;
    mdsl_frame_type      word;
    logic [GAP_W-1:0]    gap;
    logic                sclk;
    logic                sync_n;
    logic                din;
    logic                bcast;
    logic                rst_n;
  } mdsl_host_regs_type;

  localparam mdsl_host_regs_type HOST_RESET = '{
    st: HS_IDLE, div: '0, idx: '0, word: '0, gap: '0,
    sclk: 1'b1, sync_n: 1'b1, din: 1'b0, bcast: 1'b0, rst_n: 1'b0
  };

  mdsl_host_regs_type r;
  mdsl_host_regs_type r_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: clock idles high, data moves on rising edges

  always_comb begin
    r_nxt       = r;
    r_nxt.rst_n = !dev_reset_req;
    case (r.st)
      HS_IDLE: begin
        if (start && r.rst_n) begin
          r_nxt.word   = frame_pack(channel, code);
          r_nxt.din    = channel[ADDR_W-1];
          r_nxt.bcast  = broadcast_req;
          r_nxt.sync_n = 1'b0;
          r_nxt.idx    = '0;
          r_nxt.div    = '0;
          r_nxt.st     = HS_HIGH;
        end
      end
      HS_HIGH: begin
        r_nxt.div = r.div + DIV_W'(1);
        if (r.div == DIV_LAST) begin
          r_nxt.div = '0;
          if (r.idx == FRAME_CNT) begin
            r_nxt.sync_n = 1'b1;
            r_nxt.gap    = '0;
            r_nxt.st     = HS_GAP;
          end else begin
            r_nxt.sclk = 1'b0;
            r_nxt.st   = HS_LOW;
          end
        end
      end
      HS_LOW: begin
        r_nxt.div = r.div + DIV_W'(1);
        if (r.div == DIV_LAST) begin
          r_nxt.div  = '0;
          r_nxt.sclk = 1'b1;
          r_nxt.idx  = r.idx + CNT_W'(1);
          r_nxt.word = {r.word[FRAME_BITS-2:0], 1'b0};
          r_nxt.din  = r.word[FRAME_BITS-2];
          r_nxt.st   = HS_HIGH;
        end
      end
      HS_GAP: begin
        r_nxt.gap = r.gap + GAP_W'(1);
        if (r.gap == GAP_LAST) begin
          r_nxt.st = HS_IDLE;
        end
      end
      default: begin
        r_nxt.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      r <= HOST_RESET;
    end else begin
      r <= r_nxt;
    end
  end

  assign ready          = (r.st == HS_IDLE) && r.rst_n;
  assign link.sclk      = r.sclk;
  assign link.sync_n    = r.sync_n;
  assign link.din       = r.din;
  assign link.broadcast = r.bcast;
  assign link.reset_n   = r.rst_n;

endmodule // mdsl_host

/* File: testbench/mdsl_link_props.sv */
// assertions on the link signals between host end and device end
`timescale 1ns/100ps
module mdsl_link_props (
  input wire logic clock,
  input wire logic reset,
  input wire logic sync_n,
  input wire logic sclk,
  input wire logic din,
  input wire logic broadcast,
  input wire logic reset_n
);
  logic [4:0] nfall_r;

  // falls of the serial clock seen inside the current frame
  always_ff @(posedge clock) begin
    if (reset || $fell(sync_n))
      nfall_r <= 5'h00;
    else if ($fell(sclk) && !sync_n)
      nfall_r <= nfall_r + 5'h01;
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_sclk_idle_high: assert property (sync_n |-> sclk)
    else $error("serial clock moved outside a frame");
  a_low_half_fixed: assert property ($fell(sclk) |-> !sclk [*5] ##1 sclk)
    else $error("serial clock low phase wrong");
  a_high_half_min: assert property ($rose(sclk) && !sync_n |-> sclk [*5])
    else $error("serial clock high phase short");
  // while frame sync is low, data moves only in the same clock as the serial clock rises or frame sync falls
  a_din_on_rise: assert property (!sync_n && $changed(din)
    |-> $fell(sync_n) || $rose(sclk))
    else $error("data changed away from a rising clock");
  a_first_bit_hold: assert property ($fell(sync_n)
    |=> $stable(din) [*4] ##1 ($stable(din) && $fell(sclk)))
    else $error("first bit not held to first fall");
  a_nineteen_bits: assert property ($rose(sync_n) |-> nfall_r == 5'h13)
    else $error("frame bit count wrong");
  a_sync_held_low: assert property (!sync_n && (nfall_r != 5'h13) |=> !sync_n)
    else $error("frame sync rose before the frame ended");
  a_count_bound: assert property (nfall_r <= 5'h13)
    else $error("clock falls beyond frame length");
  a_frame_gap: assert property ($rose(sync_n) |-> not (##[1:49] $fell(sync_n)))
    else $error("gap between writes too short");
  a_bcast_steady: assert property (!sync_n && !$fell(sync_n) |-> $stable(broadcast))
    else $error("broadcast moved inside a frame");
  a_reset_pin_low: assert property (disable iff (1'b0) reset |=> !reset_n)
    else $error("device reset pin not low in reset");

  c_plain_frame: cover property ($rose(sync_n) && !broadcast);
  c_bcast_frame: cover property ($rose(sync_n) && broadcast);
  c_pin_reset: cover property ($fell(reset_n));
endmodule // mdsl_link_props

/* File: testbench/multichannel_dac_serial_loader_bench.sv */
// bench: host end writes channel codes to the device end over the link
`timescale 1ns/100ps
module multichannel_dac_serial_loader_bench;
  import mdsl_pkg::*;
  logic                clock;
  logic                reset;
  logic                start;
  logic [ADDR_W-1:0]   channel;
  logic [CODE_W-1:0]   code;
  logic                broadcast_req;
  logic                dev_reset_req;
  logic                ready;
  mdsl_code_array_type channel_code;
  logic                update_pulse;
  logic [ADDR_W-1:0]   update_channel;
  logic                update_broadcast;
  mdsl_frame_type      exp_frame;
  logic [31:0]         wire_bits;
  int                  wire_cnt;
  int                  failures;
  int                  checks_done;
  int                  code_m [NUM_CH];

  mdsl_link_if link ();
  mdsl_host u_mdsl_host (.clock(clock), .reset(reset), .start(start), .channel(channel),
    .code(code), .broadcast_req(broadcast_req), .dev_reset_req(dev_reset_req),
    .ready(ready), .link(link.host));
  mdsl_device u_mdsl_device (.clock(clock), .reset(reset), .link(link.device),
    .channel_code(channel_code), .update_pulse(update_pulse),
    .update_channel(update_channel), .update_broadcast(update_broadcast));
  mdsl_link_props u_mdsl_link_props (.clock(clock), .reset(reset), .sync_n(link.sync_n),
    .sclk(link.sclk), .din(link.din), .broadcast(link.broadcast), .reset_n(link.reset_n));

`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
  $display("[FAIL] %0t %h %h", $time, (a), (b)); end end

  ////////////////////////////////////////
  // own view of the wire, kept apart from the device end
  always @(negedge link.sync_n) wire_cnt = 0;
  always @(negedge link.sclk) begin
    if (!link.sync_n) begin
      wire_bits = {wire_bits[30:0], link.din};
      wire_cnt++;
    end
  end
  always @(posedge link.sync_n) begin
    if (!reset) begin
      `CHK(wire_cnt, 19)
      `CHK(wire_bits[FRAME_BITS-1:0], exp_frame)
    end
  end

  ////////////////////////////////////////
  task automatic finish_test();
    if (failures == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // kind 0 waits for ready, kind 1 for the update pulse; both bounded
  task automatic await(input int kind);
    int n;
    n = 0;
    while ((kind ? update_pulse : ready) !== 1'b1) begin
      tick(1);
      n++;
      if (n > 400) begin
        failures++;
        finish_test();
      end
    end
  endtask

  task automatic check_all();
    for (int i = 0; i < NUM_CH; i++) begin
      `CHK(channel_code[i], CODE_W'(code_m[i]))
    end
  endtask

  task automatic kick(input logic [ADDR_W-1:0] ch, input logic [CODE_W-1:0] cd,
                      input logic bc);
    await(0);
    @(posedge clock);
    start <= 1'b1;
    channel <= ch;
    code <= cd;
    broadcast_req <= bc;
    exp_frame = {ch, cd};
    @(posedge clock);
    start <= 1'b0;
  endtask

  task automatic send(input logic [ADDR_W-1:0] ch, input logic [CODE_W-1:0] cd,
                      input logic bc);
    kick(ch, cd, bc);
    await(1);
    for (int i = 0; i < NUM_CH; i++) begin
      if (bc || i == ch)
        code_m[i] = cd;
    end
    `CHK(update_channel, ch)
    `CHK(update_broadcast, bc)
    check_all();
  endtask

  ////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    reset = 1'b1;
    start = 1'b0;
    channel = '0;
    code = '0;
    broadcast_req = 1'b0;
    dev_reset_req = 1'b0;
    failures = 0;
    checks_done = 0;
    foreach (code_m[i]) code_m[i] = 0;
    void'($urandom(32'h7199));
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    tick(8);
    check_all();
    send(5'h00, 14'h3fff, 1'b0);
    send(5'h1f, 14'h0001, 1'b0);
    repeat (24) send(5'($urandom), 14'($urandom), 1'b0);
    send(5'h0a, 14'h2aaa, 1'b1);
    send(5'h15, 14'h1555, 1'b0);
    // pin reset lands a few bits into a frame; the rest must be dropped
    kick(5'h03, 14'h0fff, 1'b0);
    repeat (60) @(posedge clock);
    dev_reset_req <= 1'b1;
    repeat (10) @(posedge clock);
    dev_reset_req <= 1'b0;
    foreach (code_m[i]) code_m[i] = 0;
    await(0);
    tick(8);
    check_all();
    send(5'h03, 14'h0fff, 1'b0);
    finish_test();
  end
endmodule // multichannel_dac_serial_loader_bench
